//--- rtl/sia_aggregator.sv
// status interrupt aggregator: per-port status, summary and irq pin
// assumes single-cycle reg_rd/reg_wr strobes from the register port
`timescale 1ns/1ps
`default_nettype none
module sia_aggregator
  import sia_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  output logic                             irq_out_n,
  input  wire logic [NPORT-1:0]            lock_in,
  input  wire logic [NPORT-1:0]            pass_in,
  input  wire logic [NPORT-1:0]            parity_err_ev,
  input  wire logic [NPORT-1:0]            bc_crc_err_ev,
  input  wire logic [NPORT-1:0]            bc_seq_err_ev,
  input  wire logic [NPORT-1:0]            encode_err_ev,
  input  wire logic [NPORT-1:0]            buffer_err_ev,
  input  wire logic [NPORT-1:0]            line_len_chg_ev,
  input  wire logic [NPORT-1:0]            line_cnt_chg_ev,
  input  wire logic [NPORT-1:0]            frequency_settled,
  input  wire logic [NPORT-1:0]            no_link_clock,
  input  wire logic [NPORT-1:0]            line_length_unsettled,
  input  wire logic [NPORT-1:0][3:0]       camera_rx_err_ev,
  input  wire logic [NPORT-1:0][GPIO_W-1:0] fwd_gpio,
  input  wire logic [NPORT-1:0][SEN_W-1:0] sensor_state_byte0,
  input  wire logic [1:0]                  tx_irq_flag
);
  typedef struct packed {
    logic [7:0]                 ctl;
    logic [1:0]                 rsel;
    logic [NPORT-1:0]           wsel;
    logic [NPORT-1:0][7:0]      icr_hi;
    logic [NPORT-1:0][7:0]      icr_lo;
    logic [NPORT-1:0][7:0]      gpio_en;
    logic [NPORT-1:0][7:0]      rmask;
    logic [NPORT-1:0][7:0]      fmask;
    logic [NPORT-1:0][4:0]      s1k;
    logic [NPORT-1:0][4:0]      s2k;
    logic [NPORT-1:0][3:0]      csik;
    logic [NPORT-1:0]           lock_p;
    logic [NPORT-1:0]           pass_p;
    logic [7:0]                 rdata;
    logic                       irq_n;
  } sia_main_s;

  sia_main_s                q;
  sia_main_s                d;
  logic [NPORT-1:0][7:0]    hi_w;
  logic [NPORT-1:0][7:0]    lo_w;
  logic [NPORT-1:0]         port_irq;
  logic [7:0]               sum;
  logic                     rd_s1;
  logic                     rd_s2;
  logic                     rd_csi;
  logic                     rd_gpio;
  logic                     rd_rfl;
  logic                     rd_ffl;
  logic [NPORT-1:0]         on_rd;

  sia_edge_if eif ();

  sia_edge_bank u_edges (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .e       (eif.bank)
  );

  // read strobes; only the read-selected port sees a clearing read
  assign rd_s1   = reg_rd && (reg_addr == ADDR_STS1);
  assign rd_s2   = reg_rd && (reg_addr == ADDR_STS2);
  assign rd_csi  = reg_rd && (reg_addr == ADDR_CSI_STS);
  assign rd_gpio = reg_rd && (reg_addr == ADDR_GPIO_STS);
  assign rd_rfl  = reg_rd && (reg_addr == ADDR_SEN_RFLAG);
  assign rd_ffl  = reg_rd && (reg_addr == ADDR_SEN_FFLAG);

  // edge bank hookup: bits 11..8 gpio, 7..0 sensor byte zero
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      on_rd[p] = (q.rsel == 2'(p));
      eif.cur[p]       = {fwd_gpio[p], sensor_state_byte0[p]};
      eif.rise_mask[p] = {q.gpio_en[p][3:0], q.rmask[p]};
      eif.fall_mask[p] = {q.gpio_en[p][7:4], q.fmask[p]};
      eif.clr_rise[p]  = {{GPIO_W{rd_gpio && on_rd[p]}}, {SEN_W{rd_rfl && on_rd[p]}}};
      eif.clr_fall[p]  = {{GPIO_W{rd_gpio && on_rd[p]}}, {SEN_W{rd_ffl && on_rd[p]}}};
    end
  end

  // flag words are views of the sticky status, not storage of their own
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      hi_w[p] = {3'h0,
                 |{eif.rise[p][EDGE_W-1:SEN_W], eif.fall[p][EDGE_W-1:SEN_W]},
                 |{eif.rise[p][SEN_W-1:0], eif.fall[p][SEN_W-1:0]},
                 q.s2k[p][K2_ENC], q.s1k[p][K1_SEQ], q.s1k[p][K1_CRC]};
      lo_w[p] = {1'b0, q.s2k[p][K2_LENCHG], q.s2k[p][K2_CNTCHG], q.s2k[p][K2_BUF],
                 q.s2k[p][K2_CSI], q.s1k[p][K1_PAR], q.s1k[p][K1_PCHG],
                 q.s1k[p][K1_LCHG]};
      port_irq[p] = |(hi_w[p] & q.icr_hi[p]) || |(lo_w[p] & q.icr_lo[p]);
    end
    // source shows here with its own enable even without global enable
    sum[5:0] = {tx_irq_flag & q.ctl[5:4], port_irq & q.ctl[3:0]};
    sum[6]   = 1'b0;
    sum[SUM_GLOBAL_BIT] = |sum[5:0];
  end

  // next state: status capture, register writes, read data, pin
  always_comb
  begin
    d = q;
    d.lock_p = lock_in;
    d.pass_p = pass_in;
    for (int p = 0; p < NPORT; p++)
    begin
      // set wins over a clearing read in the same cycle; enables not consulted
      d.s1k[p] = (q.s1k[p] & {5{!(rd_s1 && on_rd[p])}}) |
                 {bc_crc_err_ev[p], lock_in[p] ^ q.lock_p[p], bc_seq_err_ev[p],
                  parity_err_ev[p], pass_in[p] ^ q.pass_p[p]};
      d.s2k[p] = (q.s2k[p] & {5{!(rd_s2 && on_rd[p])}}) |
                 {line_len_chg_ev[p], encode_err_ev[p], buffer_err_ev[p],
                  |camera_rx_err_ev[p], line_cnt_chg_ev[p]};
      if (rd_csi && on_rd[p])
        d.s2k[p][K2_CSI] = |camera_rx_err_ev[p];
      d.csik[p] = (q.csik[p] & {4{!(rd_csi && on_rd[p])}}) | camera_rx_err_ev[p];
      if (reg_wr && q.wsel[p])
      begin
        case (reg_addr)
          ADDR_ICR_HI:    d.icr_hi[p]  = reg_wdata;
          ADDR_ICR_LO:    d.icr_lo[p]  = reg_wdata;
          ADDR_GPIO_EN:   d.gpio_en[p] = reg_wdata;
          ADDR_SEN_RMASK: d.rmask[p]   = reg_wdata;
          ADDR_SEN_FMASK: d.fmask[p]   = reg_wdata;
          default:        d.rmask[p]   = q.rmask[p];
        endcase
      end
    end
    if (reg_wr && reg_addr == ADDR_CTL)
      d.ctl = reg_wdata & CTL_RW_MASK;
    if (reg_wr && reg_addr == ADDR_PSEL)
    begin
      d.rsel = reg_wdata[5:4];
      d.wsel = reg_wdata[3:0];
    end
    // read data answers one cycle after the strobe
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CTL:       d.rdata = q.ctl;
        ADDR_SUM:       d.rdata = sum;
        ADDR_PSEL:      d.rdata = {2'h0, q.rsel, q.wsel};
        ADDR_STS1:      d.rdata = {q.rsel, q.s1k[q.rsel][K1_CRC], q.s1k[q.rsel][K1_LCHG],
                                   q.s1k[q.rsel][K1_SEQ], q.s1k[q.rsel][K1_PAR],
                                   pass_in[q.rsel], lock_in[q.rsel]};
        ADDR_STS2:      d.rdata = {line_length_unsettled[q.rsel], q.s2k[q.rsel][K2_LENCHG],
                                   q.s2k[q.rsel][K2_ENC], q.s2k[q.rsel][K2_BUF],
                                   q.s2k[q.rsel][K2_CSI], frequency_settled[q.rsel],
                                   no_link_clock[q.rsel], q.s2k[q.rsel][K2_CNTCHG]};
        ADDR_ICR_HI:    d.rdata = q.icr_hi[q.rsel];
        ADDR_ICR_LO:    d.rdata = q.icr_lo[q.rsel];
        ADDR_ISR_HI:    d.rdata = hi_w[q.rsel];
        ADDR_ISR_LO:    d.rdata = lo_w[q.rsel];
        ADDR_CSI_STS:   d.rdata = {4'h0, q.csik[q.rsel]};
        ADDR_GPIO_EN:   d.rdata = q.gpio_en[q.rsel];
        ADDR_GPIO_STS:  d.rdata = {eif.fall[q.rsel][EDGE_W-1:SEN_W], eif.rise[q.rsel][EDGE_W-1:SEN_W]};
        ADDR_SEN0:      d.rdata = sensor_state_byte0[q.rsel];
        ADDR_SEN_RMASK: d.rdata = q.rmask[q.rsel];
        ADDR_SEN_FMASK: d.rdata = q.fmask[q.rsel];
        ADDR_SEN_RFLAG: d.rdata = eif.rise[q.rsel][SEN_W-1:0];
        ADDR_SEN_FFLAG: d.rdata = eif.fall[q.rsel][SEN_W-1:0];
        default:        d.rdata = 8'h00;
      endcase
    end
    // pin low only with pending enabled source and global enable
    d.irq_n = !(q.ctl[CTL_GLOBAL_BIT] && sum[SUM_GLOBAL_BIT]);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q         <= '0;
      q.ctl     <= CTL_RST;
      q.rsel    <= RSEL_RST;
      q.wsel    <= WSEL_RST;
      q.icr_hi  <= {NPORT{EN_RST}};
      q.icr_lo  <= {NPORT{EN_RST}};
      q.gpio_en <= {NPORT{EN_RST}};
      q.irq_n   <= 1'b1;
    end
    else
      q <= d;
  end

  assign reg_rdata = q.rdata;
  assign irq_out_n = q.irq_n;

  // checks on the pin, status capture and clearing, control layout and summary
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_sts1_read;
    reg_rd && reg_addr == ADDR_STS1;
  endsequence
  sequence s_flag_read;
    reg_rd && (reg_addr == ADDR_ISR_LO || reg_addr == ADDR_ISR_HI);
  endsequence

  a_pin_global: assert property (!irq_out_n |-> $past(q.ctl[CTL_GLOBAL_BIT]))
    else $error("pin low without global enable");
  a_pin_masked: assert property (!q.ctl[CTL_GLOBAL_BIT] |=> irq_out_n)
    else $error("pin low while global enable clear");
  a_pin_asserts: assert property (q.ctl[CTL_GLOBAL_BIT] && sum[SUM_GLOBAL_BIT] |=> !irq_out_n)
    else $error("pin not driven for enabled pending source");
  a_pin_release: assert property (!sum[SUM_GLOBAL_BIT] |=> irq_out_n)
    else $error("pin low with nothing pending");
  a_status_no_en: assert property (bc_crc_err_ev[2] |=> q.s1k[2][K1_CRC])
    else $error("crc status not captured");
  a_sts1_clear: assert property (s_sts1_read ##0 !bc_crc_err_ev[q.rsel]
    |=> !q.s1k[q.rsel][K1_CRC])
    else $error("first status not cleared by read");
  a_flag_read_keeps: assert property (s_flag_read ##0 q.s1k[q.rsel][K1_PAR] |=> q.s1k[q.rsel][K1_PAR])
    else $error("flag register read cleared status");
  a_ctl_write: assert property (reg_wr && reg_addr == ADDR_CTL && reg_wdata == 8'h88
    |=> q.ctl[3] && q.ctl[CTL_GLOBAL_BIT] && !q.ctl[0])
    else $error("control layout wrong");
  a_sen_change: assert property ((|eif.rise[1][SEN_W-1:0]) && q.icr_hi[1][HI_SEN_BIT] && q.ctl[1]
    |-> sum[1])
    else $error("sensor change did not reach summary");
endmodule
`default_nettype wire

//--- rtl/sia_pkg.sv
// shared constants of the status interrupt aggregator
// assumes one 200 MHz core clock and an 8-bit register port
package sia_pkg;
  localparam int NPORT  = 4;
  localparam int SEN_W  = 8;
  localparam int GPIO_W = 4;
  localparam int EDGE_W = SEN_W + GPIO_W;

  // register offsets
  localparam logic [7:0] ADDR_CTL       = 8'h23;
  localparam logic [7:0] ADDR_SUM       = 8'h24;
  localparam logic [7:0] ADDR_PSEL      = 8'h4C;
  localparam logic [7:0] ADDR_STS1      = 8'h4D;
  localparam logic [7:0] ADDR_STS2      = 8'h4E;
  localparam logic [7:0] ADDR_ICR_HI    = 8'hD8;
  localparam logic [7:0] ADDR_ICR_LO    = 8'hD9;
  localparam logic [7:0] ADDR_ISR_HI    = 8'hDA;
  localparam logic [7:0] ADDR_ISR_LO    = 8'hDB;
  localparam logic [7:0] ADDR_CSI_STS   = 8'hE0;
  localparam logic [7:0] ADDR_GPIO_EN   = 8'hE1;
  localparam logic [7:0] ADDR_GPIO_STS  = 8'hE2;
  localparam logic [7:0] ADDR_SEN0      = 8'hE3;
  localparam logic [7:0] ADDR_SEN_RMASK = 8'hE4;
  localparam logic [7:0] ADDR_SEN_FMASK = 8'hE5;
  localparam logic [7:0] ADDR_SEN_RFLAG = 8'hE6;
  localparam logic [7:0] ADDR_SEN_FFLAG = 8'hE7;

  // field positions
  localparam int CTL_GLOBAL_BIT = 7;
  localparam int SUM_GLOBAL_BIT = 7;
  localparam int HI_SEN_BIT     = 3;
  localparam int HI_GPIO_BIT    = 4;
  localparam int K1_CRC         = 4;
  localparam int K1_LCHG        = 3;
  localparam int K1_SEQ         = 2;
  localparam int K1_PAR         = 1;
  localparam int K1_PCHG        = 0;
  localparam int K2_LENCHG      = 4;
  localparam int K2_ENC         = 3;
  localparam int K2_BUF         = 2;
  localparam int K2_CSI         = 1;
  localparam int K2_CNTCHG      = 0;
  localparam logic [7:0] CTL_RW_MASK = 8'hBF;

  // values after reset
  localparam logic [7:0] CTL_RST  = 8'h00;
  localparam logic [7:0] EN_RST   = 8'h00;
  localparam logic [1:0] RSEL_RST = 2'h0;
  localparam logic [3:0] WSEL_RST = 4'h1;
endpackage

//--- rtl/sia_edge_if.sv
// edge capture signals between aggregator core and edge bank
// assumes both ends share sys_clk
`timescale 1ns/1ps
`default_nettype none
interface sia_edge_if;
  import sia_pkg::*;
  logic [NPORT-1:0][EDGE_W-1:0] cur;
  logic [NPORT-1:0][EDGE_W-1:0] rise_mask;
  logic [NPORT-1:0][EDGE_W-1:0] fall_mask;
  logic [NPORT-1:0][EDGE_W-1:0] clr_rise;
  logic [NPORT-1:0][EDGE_W-1:0] clr_fall;
  logic [NPORT-1:0][EDGE_W-1:0] rise;
  logic [NPORT-1:0][EDGE_W-1:0] fall;
  modport ctrl (output cur, rise_mask, fall_mask, clr_rise, clr_fall, input rise, fall);
  modport bank (input cur, rise_mask, fall_mask, clr_rise, clr_fall, output rise, fall);
endinterface
`default_nettype wire

//--- rtl/sia_edge_bank.sv
// masked rise/fall edge latches for sensor byte and fwd gpio bits
// assumes inputs synchronous to sys_clk and held at least a cycle
`timescale 1ns/1ps
`default_nettype none
module sia_edge_bank
  import sia_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  sia_edge_if.bank e
);
  typedef struct packed {
    logic                         armed;
    logic [NPORT-1:0][EDGE_W-1:0] prev;
    logic [NPORT-1:0][EDGE_W-1:0] rise;
    logic [NPORT-1:0][EDGE_W-1:0] fall;
  } sia_edge_s;

  sia_edge_s                    q;
  sia_edge_s                    d;
  logic [NPORT-1:0][EDGE_W-1:0] rise_ev;
  logic [NPORT-1:0][EDGE_W-1:0] fall_ev;

  // no edges before the first sample, so reset values never look like a change
  always_comb
  begin
    d = q;
    d.armed = 1'b1;
    rise_ev = '0;
    fall_ev = '0;
    for (int p = 0; p < NPORT; p++)
    begin
      if (q.armed)
      begin
        rise_ev[p] = e.cur[p] & ~q.prev[p];
        fall_ev[p] = ~e.cur[p] & q.prev[p];
      end
      // set beats clear; a clear mask forces zero
      d.rise[p] = ((q.rise[p] & ~e.clr_rise[p]) | rise_ev[p]) & e.rise_mask[p];
      d.fall[p] = ((q.fall[p] & ~e.clr_fall[p]) | fall_ev[p]) & e.fall_mask[p];
      d.prev[p] = e.cur[p];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  assign e.rise = q.rise;
  assign e.fall = q.fall;

  a_rise_latched: assert property (@(posedge sys_clk) disable iff (!reset_n)
    q.armed && e.rise_mask[1][0] && !q.prev[1][0] && e.cur[1][0] ##1 e.rise_mask[1][0] |-> q.rise[1][0])
    else $error("masked rising edge not latched");
  a_mask_zeroes: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !e.fall_mask[1][2] |=> !q.fall[1][2])
    else $error("fall flag set with mask clear");
endmodule
`default_nettype wire

//--- verif/sia_host_model.sv
// host processor model: register master on the byte port
// assumes strobes sampled on rising sys_clk, so all driving is on the falling edge
`timescale 1ns/1ps
`default_nettype none
module sia_host_model
  import sia_pkg::*;
(
  input  wire logic       sys_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one-cycle write; data inverted afterwards so nothing stale looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  // one-cycle read; data taken a full cycle later, it holds until next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  // port chosen before any per-port access
  task automatic sel(input logic [1:0] rport, input logic [3:0] wmask);
    wr(ADDR_PSEL, {2'h0, rport, wmask});
  endtask

  // enable order: source, then port, then global pin enable
  task automatic enable_port(input logic [1:0] p, input logic [7:0] lo, input logic [7:0] hi);
    sel(p, 4'h1 << p);
    wr(ADDR_ICR_LO, lo);
    wr(ADDR_ICR_HI, hi);
    wr(ADDR_CTL, 8'h01 << p);
    wr(ADDR_CTL, 8'h80 | (8'h01 << p));
  endtask
endmodule
`default_nettype wire

//--- verif/sia_aggregator_tb.sv
// self-checking bench of the status interrupt aggregator
// assumes the host model drives the register port; bench drives event inputs on falling edge
`timescale 1ns/1ps
`default_nettype none
module sia_aggregator_tb;
  import sia_pkg::*;
  logic                         sys_clk, reset_n, reg_wr, reg_rd, irq_out_n;
  logic [7:0]                   reg_addr, reg_wdata, reg_rdata, v;
  logic [NPORT-1:0]             lock_in, pass_in, parity_ev, crc_ev, seq_ev, enc_ev, buf_ev;
  logic [NPORT-1:0]             len_ev, cnt_ev, freq_ok, no_clk, len_unset;
  logic [NPORT-1:0][3:0]        cam_ev;
  logic [NPORT-1:0][GPIO_W-1:0] gpio;
  logic [NPORT-1:0][SEN_W-1:0]  sensor;
  logic [1:0]                   tx_flag;
  int                           n_fail, samples_checked;

  sia_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  sia_aggregator u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_out_n(irq_out_n), .lock_in(lock_in), .pass_in(pass_in), .parity_err_ev(parity_ev),
    .bc_crc_err_ev(crc_ev), .bc_seq_err_ev(seq_ev), .encode_err_ev(enc_ev),
    .buffer_err_ev(buf_ev), .line_len_chg_ev(len_ev), .line_cnt_chg_ev(cnt_ev),
    .frequency_settled(freq_ok), .no_link_clock(no_clk), .line_length_unsettled(len_unset),
    .camera_rx_err_ev(cam_ev), .fwd_gpio(gpio), .sensor_state_byte0(sensor),
    .tx_irq_flag(tx_flag));

  // 200 MHz core clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // read through the host model and compare
  task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, v);
    check(what, v, exp);
  endtask

  task automatic pin(input logic exp);
    check("irq pin", {7'h00, irq_out_n}, {7'h00, exp});
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // reset values, unmapped and read-only places
  task automatic t_reset();
    pin(1'b1);
    expect_reg("control", ADDR_CTL, 8'h00);
    expect_reg("summary", ADDR_SUM, 8'h00);
    expect_reg("unmapped", 8'h10, 8'h00);
    u_host.wr(ADDR_CTL, 8'hFF);
    u_host.wr(ADDR_SUM, 8'hFF);
    expect_reg("control bit6", ADDR_CTL, 8'hBF);
    expect_reg("summary ro", ADDR_SUM, 8'h00);
    u_host.wr(ADDR_CTL, 8'h88);
    expect_reg("control port3", ADDR_CTL, 8'h88);
  endtask

  // transmit flags reach the summary and the pin
  task automatic t_tx();
    u_host.wr(ADDR_CTL, 8'hB0);
    @(negedge sys_clk);
    tx_flag = 2'b10;
    repeat (2) @(negedge sys_clk);
    pin(1'b0);
    expect_reg("summary tx1", ADDR_SUM, 8'hA0);
    tx_flag = 2'b01;
    expect_reg("summary tx0", ADDR_SUM, 8'h90);
    tx_flag = 2'b00;
    repeat (3) @(negedge sys_clk);
    pin(1'b1);
    u_host.wr(ADDR_CTL, 8'h00);
  endtask

  // one-cycle event pulse on a port's parity input
  task automatic parity_pulse();
    @(negedge sys_clk);
    parity_ev[0] = 1'b1;
    @(negedge sys_clk);
    parity_ev[0] = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  // parity error raises pin, flags do not clear, first status read does
  task automatic t_parity();
    u_host.enable_port(2'd0, 8'h04, 8'h00);
    parity_pulse();
    pin(1'b0);
    expect_reg("summary rx0", ADDR_SUM, 8'h81);
    expect_reg("low flags", ADDR_ISR_LO, 8'h04);
    expect_reg("low flags kept", ADDR_ISR_LO, 8'h04);
    pin(1'b0);
    expect_reg("first status", ADDR_STS1, 8'h04);
    @(negedge sys_clk);
    pin(1'b1);
    expect_reg("first status clr", ADDR_STS1, 8'h00);
    u_host.wr(ADDR_CTL, 8'h01);
    parity_pulse();
    pin(1'b1);
    expect_reg("summary no global", ADDR_SUM, 8'h81);
    expect_reg("first status 2", ADDR_STS1, 8'h04);
    expect_reg("summary cleared", ADDR_SUM, 8'h00);
    u_host.wr(ADDR_CTL, 8'h00);
  endtask

  // disabled sources still set status; high, low and both port status layouts
  task automatic t_port2();
    u_host.sel(2'd2, 4'h4);
    @(negedge sys_clk);
    freq_ok[2] = 1'b1;
    {crc_ev[2], seq_ev[2], enc_ev[2], buf_ev[2], len_ev[2], cnt_ev[2]} = 6'h3F;
    @(negedge sys_clk);
    {crc_ev[2], seq_ev[2], enc_ev[2], buf_ev[2], len_ev[2], cnt_ev[2]} = 6'h00;
    expect_reg("high flags", ADDR_ISR_HI, 8'h07);
    expect_reg("low flags p2", ADDR_ISR_LO, 8'h70);
    expect_reg("summary off", ADDR_SUM, 8'h00);
    expect_reg("first status p2", ADDR_STS1, 8'hA8);
    expect_reg("high after first", ADDR_ISR_HI, 8'h04);
    expect_reg("second status", ADDR_STS2, 8'h75);
    expect_reg("second status clr", ADDR_STS2, 8'h04);
    expect_reg("low flags clr", ADDR_ISR_LO, 8'h00);
  endtask

  // masked rise/fall latching of the sensor byte
  task automatic t_sensor();
    u_host.sel(2'd1, 4'h2);
    u_host.wr(ADDR_SEN_RMASK, 8'h01);
    u_host.wr(ADDR_SEN_FMASK, 8'h02);
    u_host.wr(ADDR_ICR_HI, 8'h08);
    u_host.wr(ADDR_CTL, 8'h02);
    @(negedge sys_clk);
    sensor[1] = 8'h03;
    repeat (3) @(negedge sys_clk);
    expect_reg("sensor live", ADDR_SEN0, 8'h03);
    expect_reg("sensor change", ADDR_ISR_HI, 8'h08);
    expect_reg("summary sensor", ADDR_SUM, 8'h82);
    pin(1'b1);
    expect_reg("rise flags", ADDR_SEN_RFLAG, 8'h01);
    expect_reg("fall flags none", ADDR_SEN_FFLAG, 8'h00);
    expect_reg("rise flags clr", ADDR_SEN_RFLAG, 8'h00);
    expect_reg("sensor change clr", ADDR_ISR_HI, 8'h00);
    sensor[1] = 8'h00;
    repeat (3) @(negedge sys_clk);
    expect_reg("fall flags", ADDR_SEN_FFLAG, 8'h02);
    expect_reg("rise flags 2", ADDR_SEN_RFLAG, 8'h00);
  endtask

  // gpio rise on bit0 and fall on bit3 enabled; others ignored
  task automatic t_gpio();
    u_host.sel(2'd3, 4'h8);
    u_host.wr(ADDR_GPIO_EN, 8'h81);
    gpio[3] = 4'h9;
    repeat (25) @(negedge sys_clk);
    gpio[3] = 4'h1;
    repeat (25) @(negedge sys_clk);
    expect_reg("gpio change", ADDR_ISR_HI, 8'h10);
    expect_reg("gpio status", ADDR_GPIO_STS, 8'h81);
    expect_reg("gpio status clr", ADDR_GPIO_STS, 8'h00);
    expect_reg("gpio change clr", ADDR_ISR_HI, 8'h00);
  endtask

  // lock and pass changes, live levels, camera rx details cleared by their own read
  task automatic t_link0();
    u_host.sel(2'd0, 4'h1);
    @(negedge sys_clk);
    lock_in[0] = 1'b1;
    pass_in[0] = 1'b1;
    no_clk[0] = 1'b1;
    len_unset[0] = 1'b1;
    cam_ev[0] = 4'h5;
    @(negedge sys_clk);
    cam_ev[0] = 4'h0;
    expect_reg("low flags link", ADDR_ISR_LO, 8'h0B);
    expect_reg("first status link", ADDR_STS1, 8'h13);
    expect_reg("low flags csi kept", ADDR_ISR_LO, 8'h08);
    expect_reg("camera rx status", ADDR_CSI_STS, 8'h05);
    expect_reg("low flags csi clr", ADDR_ISR_LO, 8'h00);
    expect_reg("second status live", ADDR_STS2, 8'h82);
  endtask

  // main sequence; unused detail inputs stay low
  initial
  begin
    {reset_n, lock_in, pass_in, parity_ev, crc_ev, seq_ev, enc_ev, buf_ev} = '0;
    {len_ev, cnt_ev, freq_ok, no_clk, len_unset, cam_ev, gpio, sensor, tx_flag} = '0;
    n_fail = 0;
    samples_checked = 0;
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset();
    t_tx();
    t_parity();
    t_port2();
    t_sensor();
    t_gpio();
    t_link0();
    give_verdict();
  end

  // hang guard: tests need well under a thousand cycles
  initial
  begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
